// file: rtl/track_format_regs.vh
// field layouts, codes and sizes shared by the track format logic
`ifndef TRACK_FORMAT_REGS_VH
`define TRACK_FORMAT_REGS_VH
`define ADDR_FIELD_BYTES   4'h2
`define SKIP_FIELD_BYTES   4'h2
`define CHECK_CODE_BYTES   4'h6
`define GAP_BYTES          14'h0010
`define TRACK_CAPACITY     14'h20B0
`define DRIVE_BITS         5
`define DRIVE_COUNT        32
`define FLAG_DEFECT_COUNT  2
`define FLAG_DEFECT_KEY    1
`define FLAG_DEFECT_DATA   0
`define AREA_COUNT         3'h1
`define AREA_KEY           3'h2
`define AREA_DATA          3'h4
`define OP_NONE            3'h0
`define OP_WRITE_HA        3'h1
`define OP_WRITE_FORMAT    3'h2
`define OP_WRITE_UPDATE    3'h3
`define OP_READ            3'h4
`define OP_SEARCH          3'h5
`define ZERO16             16'h0000
`define ZERO14             14'h0000
`define ZERO8              8'h00
`define ZERO4              4'h0
`define ONE14              14'h0001
`define ONE4               4'h1
`define FIFO_DEPTH         8
`define FIFO_PTR_BITS      3
`endif

// file: rtl/byte_fifo.v
// parameterised valid/ready fifo holding host-bound bytes
`timescale 1ns/1ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter PTRW  = 3
) (
    // clocking
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire             clkEn,
    // fill side
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    // drain side
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTRW-1:0]  wrPtr;
    reg [PTRW-1:0]  rdPtr;
    reg [PTRW:0]    count;
    wire            doWrite;
    wire            doRead;

    assign inReady  = (count != DEPTH);
    assign outValid = (count != 0);
    assign outData  = mem[rdPtr];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            wrPtr <= {PTRW{1'b0}};
            rdPtr <= {PTRW{1'b0}};
            count <= {(PTRW+1){1'b0}};
        end else if (clkEn) begin
            if (doWrite) begin
                mem[wrPtr] <= inData;
                wrPtr      <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWrite && !doRead) begin
                count <= count + 1'b1;
            end else if (doRead && !doWrite) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// file: rtl/disk_track_format_seek_verify.v
// track formatting, defect skipping and seek verification for a disk control unit
`include "track_format_regs.vh"
`timescale 1ns/1ps
module disk_track_format_seek_verify (
    // clocking
    input  wire        sys_clk,
    input  wire        sys_rst,
    input  wire        clkEn,
    // configuration
    input  wire [1:0]  stringsFitted,
    input  wire [15:0] physBase,
    // seek command
    input  wire        seekStrobe,
    input  wire [4:0]  seekDrive,
    input  wire [15:0] seekLogical,
    output reg  [15:0] drivePhysAddr,
    output reg         driveSeekStart,
    output reg         seekRefused,
    // area command
    input  wire        areaStart,
    input  wire [2:0]  areaOp,
    input  wire [2:0]  areaKind,
    input  wire [4:0]  areaDrive,
    input  wire [13:0] areaLength,
    input  wire [13:0] areaPosition,
    // host byte stream toward disk
    input  wire [7:0]  hostWrData,
    input  wire        hostWrValid,
    output wire        hostWrReady,
    // host byte stream from disk
    output wire [7:0]  hostRdData,
    output wire        hostRdValid,
    input  wire        hostRdReady,
    // disk byte stream
    output reg  [7:0]  diskWrData,
    output reg         diskWrValid,
    output reg         diskGapSkip,
    input  wire [7:0]  diskRdData,
    input  wire        diskRdValid,
    // area results
    output reg  [15:0] lastSkipBytes,
    output reg  [7:0]  lastFlags,
    output reg         areaDone,
    output reg         unitCheck,
    output reg         seekCheck
);
    localparam ST_IDLE  = 6'h01;
    localparam ST_HDR   = 6'h02;
    localparam ST_BODY  = 6'h04;
    localparam ST_GAP   = 6'h08;
    localparam ST_CODE  = 6'h10;
    localparam ST_DONE  = 6'h20;

    reg  [5:0]  state;
    reg  [15:0] savedPhys [0:`DRIVE_COUNT-1];
    reg  [15:0] prevSkip;
    reg  [7:0]  prevFlags;
    reg  [2:0]  op;
    reg  [2:0]  kind;
    reg  [4:0]  drive;
    reg  [13:0] remain;
    reg  [13:0] pos;
    reg  [13:0] gapLeft;
    reg  [3:0]  hdrIdx;
    reg  [3:0]  codeIdx;
    reg  [15:0] hdrPhys;
    reg  [15:0] hdrSkip;
    reg  [47:0] check;
    reg         mismatch;
    reg  [7:0]  rdByte;
    reg         rdPush;
    wire        fifoReady;
    wire        isWrite;
    wire        isFormat;
    wire        hasHeader;
    wire [13:0] gapStart;
    wire        inGap;
    wire        byteGo;
    wire        gapHere;
    wire [7:0]  hdrByte;

    // fold each byte into a 48-bit check word; the gap is never folded in so
    // the code sees the record as contiguous data
    function [47:0] fold;
        input [47:0] acc;
        input [7:0]  b;
        begin
            fold = {acc[39:0], acc[47:40] ^ b ^ acc[7:0]};
        end
    endfunction

    // drive number is legal only within the fitted strings
    function drive_ok;
        input [4:0] d;
        input [1:0] s;
        begin
            drive_ok = (d[4:3] <= s);
        end
    endfunction

    assign isWrite   = (op == `OP_WRITE_HA) || (op == `OP_WRITE_FORMAT) || (op == `OP_WRITE_UPDATE);
    assign isFormat  = (op == `OP_WRITE_HA) || (op == `OP_WRITE_FORMAT);
    assign hasHeader = (kind == `AREA_COUNT);
    // gap centred on the skip field; an all-zero field parks it at track end
    assign gapStart  = (hdrSkip == `ZERO16) ? (`TRACK_CAPACITY) :
                       (hdrSkip[13:0] - (`GAP_BYTES >> 1));
    assign inGap     = (prevFlags != `ZERO8) && (pos == gapStart) && (gapLeft == `ZERO14);
    // flag bits run count, key, data from high to low, the reverse of the kind code
    assign gapHere   = inGap && ((prevFlags[`FLAG_DEFECT_COUNT:`FLAG_DEFECT_DATA] &
                       {kind[0], kind[1], kind[2]}) != 3'h0);
    assign byteGo    = isWrite ? hostWrValid : diskRdValid;
    // ready only where a host byte is really taken, never at the gap or past the body
    assign hostWrReady = isWrite && clkEn && fifoReady &&
                         ((state == ST_HDR && hdrIdx >= `ADDR_FIELD_BYTES) ||
                          (state == ST_BODY && !gapHere && remain != `ZERO14));
    assign hdrByte   = (op == `OP_WRITE_HA) ? hostWrData :
                       (hdrIdx == `ADDR_FIELD_BYTES) ? prevSkip[15:8] :
                       (hdrIdx == `ADDR_FIELD_BYTES + `ONE4) ? prevSkip[7:0] : prevFlags;

    byte_fifo #(
        .WIDTH (8),
        .DEPTH (`FIFO_DEPTH),
        .PTRW  (`FIFO_PTR_BITS)
    ) hostFifo (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .inData   (rdByte),
        .inValid  (rdPush),
        .inReady  (fifoReady),
        .outData  (hostRdData),
        .outValid (hostRdValid),
        .outReady (hostRdReady)
    );

    // seek translation; one saved address per drive
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            drivePhysAddr  <= `ZERO16;
            driveSeekStart <= 1'b0;
            seekRefused    <= 1'b0;
        end else if (clkEn) begin
            driveSeekStart <= 1'b0;
            seekRefused    <= 1'b0;
            if (seekStrobe) begin
                if (drive_ok(seekDrive, stringsFitted)) begin
                    drivePhysAddr          <= seekLogical + physBase;
                    savedPhys[seekDrive]   <= seekLogical + physBase;
                    driveSeekStart         <= 1'b1;
                end else begin
                    seekRefused <= 1'b1;
                end
            end
        end
    end

    // area engine
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state         <= ST_IDLE;
            op            <= `OP_NONE;
            kind          <= `AREA_DATA;
            drive         <= 5'h00;
            remain        <= `ZERO14;
            pos           <= `ZERO14;
            gapLeft       <= `ZERO14;
            hdrIdx        <= `ZERO4;
            codeIdx       <= `ZERO4;
            hdrPhys       <= `ZERO16;
            hdrSkip       <= `ZERO16;
            prevSkip      <= `ZERO16;
            prevFlags     <= `ZERO8;
            check         <= 48'h0000_0000_0000;
            mismatch      <= 1'b0;
            rdByte        <= `ZERO8;
            rdPush        <= 1'b0;
            diskWrData    <= `ZERO8;
            diskWrValid   <= 1'b0;
            diskGapSkip   <= 1'b0;
            lastSkipBytes <= `ZERO16;
            lastFlags     <= `ZERO8;
            areaDone      <= 1'b0;
            unitCheck     <= 1'b0;
            seekCheck     <= 1'b0;
        end else if (clkEn) begin
            rdPush      <= 1'b0;
            diskWrValid <= 1'b0;
            diskGapSkip <= 1'b0;
            areaDone    <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (areaStart) begin
                        op        <= areaOp;
                        kind      <= areaKind;
                        drive     <= areaDrive;
                        remain    <= areaLength;
                        pos       <= areaPosition;
                        gapLeft   <= `ZERO14;
                        hdrIdx    <= `ZERO4;
                        codeIdx   <= `ZERO4;
                        check     <= 48'h0000_0000_0000;
                        mismatch  <= 1'b0;
                        unitCheck <= 1'b0;
                        seekCheck <= 1'b0;
                        hdrPhys   <= savedPhys[areaDrive];
                        hdrSkip   <= prevSkip;
                        state     <= (areaKind == `AREA_COUNT) ? ST_HDR : ST_BODY;
                    end
                end
                ST_HDR: begin
                    // header order: address (2), skip (2), flag (1)
                    if (isWrite && hdrIdx < `ADDR_FIELD_BYTES) begin
                        diskWrData  <= (hdrIdx == `ZERO4) ? hdrPhys[15:8] : hdrPhys[7:0];
                        diskWrValid <= 1'b1;
                        check       <= fold(check, (hdrIdx == `ZERO4) ? hdrPhys[15:8] : hdrPhys[7:0]);
                        hdrIdx      <= hdrIdx + `ONE4;
                    end else if (byteGo && (!isWrite || fifoReady)) begin
                        if (isWrite) begin
                            if (op == `OP_WRITE_HA) begin
                                if (hdrIdx == `ADDR_FIELD_BYTES) begin
                                    prevSkip[15:8] <= hostWrData;
                                end else if (hdrIdx == `ADDR_FIELD_BYTES + `ONE4) begin
                                    prevSkip[7:0] <= hostWrData;
                                end else begin
                                    prevFlags <= hostWrData;
                                end
                            end
                            diskWrData  <= hdrByte;
                            diskWrValid <= 1'b1;
                            check       <= fold(check, hdrByte);
                        end else begin
                            check <= fold(check, diskRdData);
                            if (hdrIdx < `ADDR_FIELD_BYTES) begin
                                if (hdrIdx == `ZERO4) begin
                                    mismatch <= (diskRdData != hdrPhys[15:8]);
                                end else begin
                                    mismatch <= mismatch || (diskRdData != hdrPhys[7:0]);
                                end
                            end else if (mismatch) begin
                                // wrong address: stop before any header byte goes up
                                state <= ST_DONE;
                            end else begin
                                rdByte <= diskRdData;
                                rdPush <= 1'b1;
                                if (hdrIdx == `ADDR_FIELD_BYTES) begin
                                    prevSkip[15:8] <= diskRdData;
                                end else if (hdrIdx == `ADDR_FIELD_BYTES + `ONE4) begin
                                    prevSkip[7:0] <= diskRdData;
                                end else begin
                                    prevFlags <= diskRdData;
                                end
                            end
                        end
                        if (hdrIdx == `ADDR_FIELD_BYTES + `SKIP_FIELD_BYTES) begin
                            state <= ST_BODY;
                        end
                        hdrIdx <= hdrIdx + `ONE4;
                    end
                end
                ST_BODY: begin
                    if (gapHere) begin
                        gapLeft <= `GAP_BYTES;
                        state   <= ST_GAP;
                    end else if (remain == `ZERO14) begin
                        state <= ST_CODE;
                    end else if (byteGo && (!isWrite || fifoReady)) begin
                        if (isWrite) begin
                            diskWrData  <= hostWrData;
                            diskWrValid <= 1'b1;
                            check       <= fold(check, hostWrData);
                        end else begin
                            rdByte <= diskRdData;
                            rdPush <= !(op == `OP_SEARCH);
                            check  <= fold(check, diskRdData);
                        end
                        remain <= remain - `ONE14;
                        pos    <= pos + `ONE14;
                    end
                end
                ST_GAP: begin
                    // gap bytes pass with neither data transfer nor error
                    diskGapSkip <= 1'b1;
                    if (gapLeft == `ONE14) begin
                        state <= ST_BODY;
                        pos   <= pos + `ONE14;
                        gapLeft <= `ZERO14;
                    end else begin
                        gapLeft <= gapLeft - `ONE14;
                        pos     <= pos + `ONE14;
                    end
                    if (!isFormat && gapLeft == `ONE14) begin
                        gapLeft <= `GAP_BYTES;
                    end
                end
                ST_CODE: begin
                    if (isWrite) begin
                        diskWrData  <= check[47:40];
                        diskWrValid <= 1'b1;
                        check       <= {check[39:0], `ZERO8};
                        codeIdx     <= codeIdx + `ONE4;
                        if (codeIdx == `CHECK_CODE_BYTES - `ONE4) begin
                            state <= ST_DONE;
                        end
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    areaDone      <= 1'b1;
                    lastSkipBytes <= prevSkip;
                    lastFlags     <= prevFlags;
                    unitCheck     <= !isWrite && hasHeader && mismatch;
                    seekCheck     <= !isWrite && hasHeader && mismatch;
                    state         <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// file: dv/disk_track_format_checker.sv
// concurrent checks on seek translation, header insertion, gap skipping and error reporting
`timescale 1ns/1ps
module disk_track_format_checker (
    // clocking
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        clkEn,
    // seek side
    input wire logic [1:0]  stringsFitted,
    input wire logic [15:0] physBase,
    input wire logic        seekStrobe,
    input wire logic [4:0]  seekDrive,
    input wire logic [15:0] seekLogical,
    input wire logic [15:0] drivePhysAddr,
    input wire logic        driveSeekStart,
    input wire logic        seekRefused,
    // area side
    input wire logic        areaStart,
    input wire logic [2:0]  areaOp,
    input wire logic [2:0]  areaKind,
    input wire logic [4:0]  areaDrive,
    input wire logic [7:0]  diskWrData,
    input wire logic        diskWrValid,
    input wire logic        diskGapSkip,
    input wire logic        areaDone,
    input wire logic        unitCheck,
    input wire logic        seekCheck
);
    logic [15:0] savedPhys [0:31];
    logic [4:0]  gapCnt;
    logic [2:0]  lastOp;

    // per-drive seek address shadow, gap run counter and last area op
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            gapCnt <= 5'h00;
            lastOp <= 3'h0;
        end else begin
            gapCnt <= diskGapSkip ? gapCnt + 5'h01 : 5'h00;
            if (areaStart && clkEn)
                lastOp <= areaOp;
            if (seekStrobe && clkEn && seekDrive[4:3] <= stringsFitted)
                savedPhys[seekDrive] <= seekLogical + physBase;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_addrBytes(logic [15:0] a);
        diskWrValid && diskWrData == a[15:8] ##1 diskWrValid && diskWrData == a[7:0];
    endsequence
    property p_seekAnswer;
        seekStrobe && clkEn && seekDrive[4:3] <= stringsFitted |=> driveSeekStart && !seekRefused
            && drivePhysAddr == $past(seekLogical) + $past(physBase);
    endproperty
    property p_seekRefuse;
        seekStrobe && clkEn && seekDrive[4:3] > stringsFitted |=> seekRefused && !driveSeekStart;
    endproperty
    property p_addrBytes;
        areaStart && clkEn && (areaOp == 3'h1 || areaOp == 3'h2) && areaKind == 3'h1
            |-> ##2 s_addrBytes(savedPhys[areaDrive]);
    endproperty
    property p_gapLen;
        $fell(diskGapSkip) |-> gapCnt == 5'h10;
    endproperty
    property p_gapQuiet;
        diskGapSkip |-> !diskWrValid;
    endproperty
    property p_doneOnce;
        areaDone |=> !areaDone;
    endproperty
    property p_checkHold;
        unitCheck && !(areaStart && clkEn) |=> unitCheck;
    endproperty
    property p_seekCheckUnit;
        seekCheck |-> unitCheck;
    endproperty
    property p_errOnlyReads;
        unitCheck |-> lastOp == 3'h4 || lastOp == 3'h5;
    endproperty

    a_seekAnswer: assert property (p_seekAnswer)
        else $error("seek not answered with translated address");
    a_seekRefuse: assert property (p_seekRefuse)
        else $error("seek beyond fitted strings not refused");
    a_addrBytes: assert property (p_addrBytes)
        else $error("header does not start with saved physical address");
    a_gapLen: assert property (p_gapLen)
        else $error("defect gap length wrong");
    a_gapQuiet: assert property (p_gapQuiet)
        else $error("data written inside defect gap");
    a_doneOnce: assert property (p_doneOnce)
        else $error("completion pulse longer than one cycle");
    a_checkHold: assert property (p_checkHold)
        else $error("unit check dropped before next area");
    a_seekCheckUnit: assert property (p_seekCheckUnit)
        else $error("seek check without unit check");
    a_errOnlyReads: assert property (p_errOnlyReads)
        else $error("error raised outside read or search");
endmodule

bind disk_track_format_seek_verify disk_track_format_checker i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .stringsFitted(stringsFitted), .physBase(physBase),
    .seekStrobe(seekStrobe), .seekDrive(seekDrive), .seekLogical(seekLogical), .drivePhysAddr(drivePhysAddr),
    .driveSeekStart(driveSeekStart), .seekRefused(seekRefused), .areaStart(areaStart), .areaOp(areaOp),
    .areaKind(areaKind), .areaDrive(areaDrive), .diskWrData(diskWrData), .diskWrValid(diskWrValid),
    .diskGapSkip(diskGapSkip), .areaDone(areaDone), .unitCheck(unitCheck), .seekCheck(seekCheck)
);

// file: dv/disk_string_model.sv
// drive string model: logs bytes written to disk, replays bytes loaded by the bench
`timescale 1ns/1ps
module disk_string_model (
    // clocking
    input  wire logic       sys_clk,
    // disk byte stream
    input  wire logic [7:0] diskWrData,
    input  wire logic       diskWrValid,
    input  wire logic       diskGapSkip,
    output logic      [7:0] diskRdData,
    output logic            diskRdValid
);
    logic [7:0] wrLog [$];
    logic [7:0] playQ [$];
    int         gapCycles;

    initial begin
        diskRdData = 8'h00;
        diskRdValid = 1'b0;
        gapCycles = 0;
    end

    always @(posedge sys_clk) begin
        if (diskWrValid === 1'b1)
            wrLog.push_back(diskWrData);
        if (diskGapSkip === 1'b1)
            gapCycles++;
        if (playQ.size() > 0) begin
            diskRdValid <= 1'b1;
            diskRdData <= playQ.pop_front();
        end else begin
            // released line toggles so a stale byte can never be mistaken for data
            diskRdValid <= 1'b0;
            diskRdData <= ~diskRdData;
        end
    end

    task load(input logic [7:0] b);
        playQ.push_back(b);
    endtask
endmodule

// file: dv/disk_track_format_seek_verify_bench.sv
// self-checking bench: seeks, header writes, gap skipping, reads and seek verification
`timescale 1ns/1ps
module disk_track_format_seek_verify_bench;
    logic        sys_clk, sys_rst, clkEn, seekStrobe, areaStart, hostWrValid, hostRdReady;
    logic [1:0]  stringsFitted;
    logic [15:0] physBase, seekLogical, drivePhysAddr, lastSkipBytes;
    logic [4:0]  seekDrive, areaDrive;
    logic [2:0]  areaOp, areaKind;
    logic [13:0] areaLength, areaPosition;
    logic [7:0]  hostWrData, hostRdData, diskWrData, diskRdData, lastFlags;
    logic        driveSeekStart, seekRefused, hostWrReady, hostRdValid, diskWrValid, diskGapSkip, diskRdValid;
    logic        areaDone, unitCheck, seekCheck;
    logic [7:0]  rxq [$];
    int          err_total, compares;

    disk_track_format_seek_verify i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .stringsFitted(stringsFitted), .physBase(physBase),
        .seekStrobe(seekStrobe), .seekDrive(seekDrive), .seekLogical(seekLogical), .drivePhysAddr(drivePhysAddr),
        .driveSeekStart(driveSeekStart), .seekRefused(seekRefused), .areaStart(areaStart), .areaOp(areaOp),
        .areaKind(areaKind), .areaDrive(areaDrive), .areaLength(areaLength), .areaPosition(areaPosition),
        .hostWrData(hostWrData), .hostWrValid(hostWrValid), .hostWrReady(hostWrReady), .hostRdData(hostRdData),
        .hostRdValid(hostRdValid), .hostRdReady(hostRdReady), .diskWrData(diskWrData), .diskWrValid(diskWrValid),
        .diskGapSkip(diskGapSkip), .diskRdData(diskRdData), .diskRdValid(diskRdValid),
        .lastSkipBytes(lastSkipBytes), .lastFlags(lastFlags), .areaDone(areaDone), .unitCheck(unitCheck),
        .seekCheck(seekCheck)
    );
    disk_string_model i_disk (
        .sys_clk(sys_clk), .diskWrData(diskWrData), .diskWrValid(diskWrValid), .diskGapSkip(diskGapSkip),
        .diskRdData(diskRdData), .diskRdValid(diskRdValid)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (hostRdValid === 1'b1 && hostRdReady === 1'b1)
            rxq.push_back(hostRdData);
    end

    task conclude;
        $display("mismatches %0d comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task hang(input string msg);
        chk(1'b0, msg);
        conclude;
    endtask
    task tick;
        @(posedge sys_clk);
        #1;
    endtask
    task seek(input logic [4:0] d, input logic [15:0] la, input logic ok);
        seekDrive = d;
        seekLogical = la;
        seekStrobe = 1'b1;
        tick;
        chk(driveSeekStart === ok && seekRefused === !ok, "seek answer");
        seekStrobe = 1'b0;
        tick;
    endtask
    task start(input logic [2:0] op, input logic [2:0] kind, input logic [4:0] d, input logic [13:0] len,
               input logic [13:0] pos);
        areaOp = op;
        areaKind = kind;
        areaDrive = d;
        areaLength = len;
        areaPosition = pos;
        areaStart = 1'b1;
        tick;
        areaStart = 1'b0;
        i_disk.wrLog.delete();
        i_disk.gapCycles = 0;
    endtask
    task waitDone;
        int n;
        for (n = 0; n < 500 && areaDone !== 1'b1; n++)
            tick;
        if (n == 500)
            hang("area never completed");
    endtask
    // valid stays up between bytes; caller drops it
    task send(input logic [7:0] b);
        int n;
        hostWrData = b;
        hostWrValid = 1'b1;
        for (n = 0; n < 500 && hostWrReady !== 1'b1; n++)
            tick;
        if (n == 500)
            hang("host byte never accepted");
        tick;
    endtask
    task writeArea(input logic [2:0] op, input logic [2:0] kind, input logic [13:0] len, input logic [13:0] pos,
                   input logic [23:0] hdr);
        int i;
        start(op, kind, 5'h03, len, pos);
        if (kind == 3'h1)
            for (i = 2; i >= 0; i--)
                send(hdr[i*8 +: 8]);
        for (i = 0; i < len; i++)
            send(8'h40 + i[7:0]);
        hostWrValid = 1'b0;
        waitDone;
    endtask
    // count area read, five body bytes; hold stalls the host
    task readArea(input logic [2:0] op, input logic [4:0] d, input logic [15:0] pa, input logic err,
                  input logic hold);
        int i;
        rxq.delete();
        hostRdReady = !hold;
        start(op, 3'h1, d, 14'h0005, 14'h0000);
        for (i = 0; i < 16; i++)
            i_disk.load(i < 2 ? pa[15-8*i -: 8] : i == 3 ? 8'h20 : i == 4 ? 8'h01 :
                        (i > 4 && i < 10) ? 8'h5a + i[7:0] : 8'h00);
        waitDone;
        chk(unitCheck === err && seekCheck === err, "verification status");
        i_disk.playQ.delete();
        if (hold)
            chk(hostRdValid === 1'b1 && rxq.size() == 0, "fifo holds bytes while host stalls");
        hostRdReady = 1'b1;
        for (i = 0; i < 20; i++)
            tick;
        chk(hostRdValid === 1'b0, "fifo drained");
        if (op == 3'h4 && !err)
            chk(rxq.size() == 8 && rxq[0] === 8'h00 && rxq[1] === 8'h20 && rxq[2] === 8'h01
                && rxq[3] === 8'h5f && rxq[7] === 8'h63, "host bytes without address");
    endtask

    initial begin
        err_total = 0;
        compares = 0;
        sys_rst = 1'b1;
        clkEn = 1'b1;
        stringsFitted = 2'h1;
        physBase = 16'h0100;
        {seekStrobe, seekDrive, seekLogical, areaStart, areaOp, areaKind, areaDrive} = '0;
        {areaLength, areaPosition, hostWrData, hostWrValid} = '0;
        hostRdReady = 1'b1;
        repeat (10) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        seek(5'h10, 16'h0203, 1'b0);
        seek(5'h0b, 16'h0400, 1'b1);
        chk(drivePhysAddr === 16'h0500, "translated address drive 11");
        seek(5'h03, 16'h0203, 1'b1);
        chk(drivePhysAddr === 16'h0303, "translated address drive 3");
        writeArea(3'h1, 3'h1, 14'h0004, 14'h0000, 24'h00_2001);
        chk(i_disk.wrLog.size() == 15 && {i_disk.wrLog[0], i_disk.wrLog[1]} === 16'h0303, "address bytes");
        chk({i_disk.wrLog[2], i_disk.wrLog[3], i_disk.wrLog[4]} === 24'h00_2001, "host header");
        chk(lastSkipBytes === 16'h0020 && lastFlags === 8'h01, "recorded skip and flags");
        writeArea(3'h2, 3'h1, 14'h0004, 14'h000c, 24'haa_bbcc);
        chk({i_disk.wrLog[2], i_disk.wrLog[3], i_disk.wrLog[4]} === 24'h00_2001, "copied header");
        writeArea(3'h2, 3'h4, 14'h0028, 14'h0010, 24'h00_0000);
        chk(i_disk.gapCycles == 16, "gap length");
        chk(i_disk.wrLog.size() == 46, "data around gap with check bytes");
        writeArea(3'h3, 3'h4, 14'h0008, 14'h0040, 24'h00_0000);
        chk(unitCheck === 1'b0 && i_disk.wrLog.size() == 14, "update write");
        readArea(3'h4, 5'h03, 16'h0303, 1'b0, 1'b1);
        readArea(3'h5, 5'h03, 16'h0304, 1'b1, 1'b0);
        readArea(3'h4, 5'h0b, 16'h0500, 1'b0, 1'b0);
        readArea(3'h5, 5'h03, 16'h0303, 1'b0, 1'b0);
        conclude;
    end
endmodule
